// ===== rtc_alarm_shift_timestamp_regs.sv
// Purpose: Alarm compare, protection key, sub-second readout, shift and stamp registers.
// Assumes: Calendar and stamp source share this clock; the prescaler count comes from another.
// Notes: rst_n is the clock-domain reset; sys_rst_n is the system reset.
//
// Strobed register access was decided locally.
`timescale 1ns/1ps
`default_nettype none
// Operation
// - Alarm writes need write-allowed flag or initialisation.
// - Bit 31 ignores date or weekday.
// - Bit 30 makes units a weekday.
// - Bit 23 ignores hours.
// - Bit 15 ignores minutes.
// - Bit 7 ignores seconds.
// - Date, afternoon and hour fields positions.
// - Minute and second fields, all read/write.
// - Afternoon bit one means afternoon.
// - Clock reset clears alarm, shift, stamp registers.
// - Locked protection ignores alarm and shift writes.
// - Key is write-only byte, reads zero.
// - Sub-second reads prescaler down-counter.
// - System reset zeroes readout unless bypassed.
// - Count above prescale only after shift.
// - Add-one-second bit is write-only, held until the next accepted shift write.
// - Fraction write adds to prescaler counter.
// - Shift writes ignored while shift pending.
// - Fraction write clears shadow synced flag.
// - Stamp time valid only with stamp flag.
// - Shift write sets pending until executed.
// - Stamp event sets flag, captures time.
// - Alarm flag set on unmasked match.
module rtc_alarm_shift_timestamp_regs (
	input wire logic clock,
	input wire logic rst_n,
	input wire logic sys_rst_n,
	input wire logic clk_en,
	input wire logic [7:0] addr,
	input wire logic [31:0] wdata,
	input wire logic wr_en,
	input wire logic rd_en,
	output logic [31:0] rdata,
	input wire logic [15:0] prescaler_count,
	input wire logic [31:0] cal_time,
	input wire logic [31:0] cal_date,
	input wire logic cal_advance,
	input wire logic shadow_copy,
	input wire logic shift_done,
	input wire logic stamp_event,
	output logic shift_add_second,
	output logic [14:0] shift_fraction,
	output logic shift_strobe,
	output logic alarm_flag,
	output logic stamp_flag,
	output logic shift_pending,
	output logic shadow_synced_flag
);
	typedef enum logic [2:0] {
		lock_closed = 3'b001,
		lock_half = 3'b010,
		lock_open = 3'b100
	} lock_t;
	typedef struct packed {
		lock_t lock;
		logic [31:0] alarm;
		logic [31:0] stamp;
		logic [15:0] subsec;
		logic stamp_flag;
		logic alarm_flag;
		logic pending;
		logic synced;
		logic init_mode;
		logic alarm_en;
		logic bypass;
		logic add_sec;
		logic [14:0] fraction;
		logic strobe;
		logic [31:0] rdata;
	} state_t;
	state_t s_r;
	state_t s_nxt;
	logic [15:0] presc_s1_r;
	logic [15:0] presc_s2_r;
	logic [15:0] presc_s3_r;
	logic wr_key;
	logic wr_control;
	logic wr_status;
	logic wr_alarm;
	logic wr_shift;
	logic match;
	function automatic logic field_eq(input logic [31:0] a, input logic [31:0] b,
		input int lsb, input logic [7:0] m);
		field_eq = ((a >> lsb) & 32'(m)) == ((b >> lsb) & 32'(m));
	endfunction : field_eq
	function automatic logic addr_hit(input logic [7:0] a, input logic [7:0] off);
		addr_hit = a == off;
	endfunction : addr_hit
	// Prescaler count is on another clock; a word is taken only once two samples agree.
	always_ff @(posedge clock) begin
		if (clk_en) begin
			presc_s1_r <= prescaler_count;
			presc_s2_r <= presc_s1_r;
			presc_s3_r <= presc_s2_r;
		end
	end
	assign wr_key = wr_en && addr_hit(addr, rtc_regs_pkg::off_key);
	assign wr_control = wr_en && addr_hit(addr, rtc_regs_pkg::off_control);
	assign wr_status = wr_en && addr_hit(addr, rtc_regs_pkg::off_status);
	assign wr_alarm = wr_en && addr_hit(addr, rtc_regs_pkg::off_alarm) && s_r.lock == lock_open
		&& (!s_r.alarm_en || s_r.init_mode);
	assign wr_shift = wr_en && addr_hit(addr, rtc_regs_pkg::off_shift) && s_r.lock == lock_open
		&& !s_r.pending;
	always_comb begin
		logic d_ok;
		logic h_ok;
		logic m_ok;
		logic sec_ok;
		d_ok = 1'b0;
		h_ok = 1'b0;
		m_ok = 1'b0;
		sec_ok = 1'b0;
		if (s_r.alarm[rtc_regs_pkg::bit_weekday_select]) begin
			d_ok = field_eq(s_r.alarm, {5'h00, cal_date[15:13], 24'h000000}, rtc_regs_pkg::lsb_date,
				rtc_regs_pkg::weekday_units_mask);
		end else begin
			d_ok = field_eq(s_r.alarm, {2'b00, cal_date[5:0], 24'h000000}, rtc_regs_pkg::lsb_date,
				rtc_regs_pkg::date_tens_units_mask);
		end
		h_ok = field_eq(s_r.alarm, cal_time, rtc_regs_pkg::lsb_hour,
			rtc_regs_pkg::hour_field_mask);
		m_ok = field_eq(s_r.alarm, cal_time, rtc_regs_pkg::lsb_minute,
			rtc_regs_pkg::ms_field_mask);
		sec_ok = field_eq(s_r.alarm, cal_time, rtc_regs_pkg::lsb_second,
			rtc_regs_pkg::ms_field_mask);
		match = (s_r.alarm[rtc_regs_pkg::bit_date_ignore] || d_ok)
			&& (s_r.alarm[rtc_regs_pkg::bit_hours_ignore] || h_ok)
			&& (s_r.alarm[rtc_regs_pkg::bit_minutes_ignore] || m_ok)
			&& (s_r.alarm[rtc_regs_pkg::bit_seconds_ignore] || sec_ok);
	end
	always_comb begin
		s_nxt = s_r;
		s_nxt.strobe = 1'b0;
		s_nxt.rdata = 32'h0000_0000;
		if (presc_s2_r == presc_s3_r)
			s_nxt.subsec = presc_s2_r;
		if (wr_key) begin
			unique case (s_r.lock)
				lock_closed: s_nxt.lock = (wdata[7:0] == rtc_regs_pkg::key_first) ?
					lock_half : lock_closed;
				lock_half: s_nxt.lock = (wdata[7:0] == rtc_regs_pkg::key_second) ?
					lock_open : lock_closed;
				lock_open: s_nxt.lock = lock_closed;
			endcase
		end
		if (wr_alarm)
			s_nxt.alarm = wdata;
		if (wr_control) begin
			s_nxt.init_mode = wdata[rtc_regs_pkg::st_init];
			s_nxt.alarm_en = wdata[rtc_regs_pkg::ct_alarm_enable];
			s_nxt.bypass = wdata[rtc_regs_pkg::ct_shadow_bypass];
		end
		if (shadow_copy)
			s_nxt.synced = 1'b1;
		if (s_r.init_mode || s_r.pending || s_r.bypass)
			s_nxt.synced = 1'b0;
		if (shift_done)
			s_nxt.pending = 1'b0;
		if (wr_shift) begin
			s_nxt.add_sec = wdata[rtc_regs_pkg::bit_add_one_second];
			s_nxt.fraction = wdata[14:0];
			s_nxt.strobe = 1'b1;
			s_nxt.pending = 1'b1;
			if (wdata[14:0] != 15'h0000)
				s_nxt.synced = 1'b0;
		end
		if (wr_status) begin
			if (!wdata[rtc_regs_pkg::st_alarm_flag])
				s_nxt.alarm_flag = 1'b0;
			if (!wdata[rtc_regs_pkg::st_stamp_flag]) begin
				s_nxt.stamp_flag = 1'b0;
				s_nxt.stamp = 32'h0000_0000;
			end
			if (!wdata[rtc_regs_pkg::st_shadow_synced])
				s_nxt.synced = 1'b0;
		end
		if (cal_advance && s_r.alarm_en && !s_r.init_mode && match)
			s_nxt.alarm_flag = 1'b1;
		if (stamp_event) begin
			s_nxt.stamp_flag = 1'b1;
			s_nxt.stamp = cal_time & rtc_regs_pkg::stamp_time_mask;
		end
		if (rd_en) begin
			unique case (addr)
				rtc_regs_pkg::off_alarm: s_nxt.rdata = s_r.alarm;
				rtc_regs_pkg::off_subsec: s_nxt.rdata = {16'h0000, s_r.subsec};
				rtc_regs_pkg::off_stamp: s_nxt.rdata = s_r.stamp;
				rtc_regs_pkg::off_control: s_nxt.rdata = {23'h0, s_r.alarm_en, 2'b00,
					s_r.bypass, 5'h00} | (32'(s_r.init_mode) << rtc_regs_pkg::st_init);
				rtc_regs_pkg::off_status: s_nxt.rdata = {15'h0, s_r.lock == lock_open,
					4'h0, s_r.stamp_flag, 2'b00, s_r.alarm_flag, 1'b0, s_r.init_mode,
					s_r.synced, 1'b0, s_r.pending, 2'b00,
					!s_r.alarm_en || s_r.init_mode};
				default: s_nxt.rdata = 32'h0000_0000;
			endcase
		end
	end
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			s_r.lock <= lock_closed;
			s_r.alarm <= rtc_regs_pkg::alarm_reset;
			s_r.stamp <= 32'h0000_0000;
			s_r.subsec <= 16'h0000;
			s_r.stamp_flag <= 1'b0;
			s_r.alarm_flag <= 1'b0;
			s_r.pending <= 1'b0;
			s_r.synced <= 1'b0;
			s_r.init_mode <= 1'b0;
			s_r.alarm_en <= 1'b0;
			s_r.bypass <= 1'b0;
			s_r.add_sec <= 1'b0;
			s_r.fraction <= 15'h0000;
			s_r.strobe <= 1'b0;
			s_r.rdata <= 32'h0000_0000;
		end else if (!sys_rst_n) begin
			s_r.lock <= lock_closed;
			s_r.rdata <= 32'h0000_0000;
			s_r.strobe <= 1'b0;
			if (!s_r.bypass)
				s_r.subsec <= 16'h0000;
		end else if (clk_en) begin
			s_r <= s_nxt;
		end
	end
	assign rdata = s_r.rdata;
	assign shift_add_second = s_r.add_sec;
	assign shift_fraction = s_r.fraction;
	assign shift_strobe = s_r.strobe;
	assign alarm_flag = s_r.alarm_flag;
	assign stamp_flag = s_r.stamp_flag;
	assign shift_pending = s_r.pending;
	assign shadow_synced_flag = s_r.synced;
	property p_locked_alarm;
		@(posedge clock) disable iff (!rst_n || !sys_rst_n)
		(clk_en && wr_en && addr == rtc_regs_pkg::off_alarm && s_r.lock != lock_open)
			|=> $stable(s_r.alarm);
	endproperty
	a_locked_alarm: assert property (p_locked_alarm) else $error("locked alarm write took");

	property p_pending_block;
		@(posedge clock) disable iff (!rst_n || !sys_rst_n)
		(clk_en && s_r.pending && !shift_done) |=> !shift_strobe;
	endproperty
	a_pending_block: assert property (p_pending_block) else $error("shift while pending");

	property p_shift_sets;
		@(posedge clock) disable iff (!rst_n || !sys_rst_n)
		(clk_en && wr_shift) |=> shift_pending && shift_strobe;
	endproperty
	a_shift_sets: assert property (p_shift_sets) else $error("pending not set");

	property p_stamp;
		@(posedge clock) disable iff (!rst_n || !sys_rst_n)
		(clk_en && stamp_event) |=> stamp_flag;
	endproperty
	a_stamp: assert property (p_stamp) else $error("stamp flag not set");

	property p_stamp_zero;
		@(posedge clock) disable iff (!rst_n)
		!stamp_flag |-> s_r.stamp == 32'h0000_0000;
	endproperty
	a_stamp_zero: assert property (p_stamp_zero) else $error("stamp held without flag");

	property p_key_reads_zero;
		@(posedge clock) disable iff (!rst_n || !sys_rst_n)
		(clk_en && rd_en && addr == rtc_regs_pkg::off_key) |=> rdata == 32'h0000_0000;
	endproperty
	a_key_reads_zero: assert property (p_key_reads_zero) else $error("key read nonzero");

	property p_alarm_match;
		@(posedge clock) disable iff (!rst_n || !sys_rst_n)
		(clk_en && cal_advance && s_r.alarm_en && !s_r.init_mode && match) |=> alarm_flag;
	endproperty
	a_alarm_match: assert property (p_alarm_match) else $error("alarm flag missed");

	property p_fraction_sync;
		@(posedge clock) disable iff (!rst_n || !sys_rst_n)
		(clk_en && wr_shift && wdata[14:0] != 15'h0000) |=> !shadow_synced_flag;
	endproperty
	a_fraction_sync: assert property (p_fraction_sync) else $error("synced not cleared");

	property p_shift_reads_zero;
		@(posedge clock) disable iff (!rst_n || !sys_rst_n)
		(clk_en && rd_en && addr == rtc_regs_pkg::off_shift) |=> rdata == 32'h0000_0000;
	endproperty
	a_shift_reads_zero: assert property (p_shift_reads_zero) else $error("shift read nonzero");

	property p_clock_reset;
		@(posedge clock)
		!rst_n |=> s_r.alarm == rtc_regs_pkg::alarm_reset && s_r.stamp == 32'h0000_0000 && !shift_pending;
	endproperty
	a_clock_reset: assert property (p_clock_reset) else $error("clock reset not cleared");

	property p_sys_keeps;
		@(posedge clock)
		(rst_n && !sys_rst_n) |=> !rst_n || ($stable(s_r.alarm) && $stable(s_r.stamp));
	endproperty
	a_sys_keeps: assert property (p_sys_keeps) else $error("system reset changed alarm");

	property p_sys_subsec;
		@(posedge clock)
		(rst_n && !sys_rst_n && !s_r.bypass) |=> s_r.subsec == 16'h0000;
	endproperty
	a_sys_subsec: assert property (p_sys_subsec) else $error("readout not zeroed");

	property p_sys_bypass;
		@(posedge clock)
		(rst_n && !sys_rst_n && s_r.bypass) |=> !rst_n || $stable(s_r.subsec);
	endproperty
	a_sys_bypass: assert property (p_sys_bypass) else $error("bypassed readout changed");

	property p_rdata_idle;
		@(posedge clock) disable iff (!rst_n || !sys_rst_n)
		(clk_en && !rd_en) |=> rdata == 32'h0000_0000;
	endproperty
	a_rdata_idle: assert property (p_rdata_idle) else $error("read data without read");

	property p_no_false_alarm;
		@(posedge clock) disable iff (!rst_n || !sys_rst_n)
		(clk_en && !cal_advance && !alarm_flag) |=> !alarm_flag;
	endproperty
	a_no_false_alarm: assert property (p_no_false_alarm) else $error("alarm without advance");

	property p_alarm_lands;
		@(posedge clock) disable iff (!rst_n || !sys_rst_n)
		(clk_en && wr_alarm) |=> s_r.alarm == $past(wdata);
	endproperty
	a_alarm_lands: assert property (p_alarm_lands) else $error("alarm write lost");

	property p_refused_alarm;
		@(posedge clock) disable iff (!rst_n || !sys_rst_n)
		(clk_en && wr_en && addr == rtc_regs_pkg::off_alarm && s_r.alarm_en && !s_r.init_mode)
			|=> $stable(s_r.alarm);
	endproperty
	a_refused_alarm: assert property (p_refused_alarm) else $error("disallowed alarm write took");

	property p_done_clears;
		@(posedge clock) disable iff (!rst_n || !sys_rst_n)
		(clk_en && shift_done && !wr_shift) |=> !shift_pending;
	endproperty
	a_done_clears: assert property (p_done_clears) else $error("pending not cleared");

	property p_strobe_single;
		@(posedge clock) disable iff (!rst_n || !sys_rst_n)
		(clk_en && shift_strobe) |=> !shift_strobe;
	endproperty
	a_strobe_single: assert property (p_strobe_single) else $error("shift strobe too long");

	property p_stamp_capture;
		@(posedge clock) disable iff (!rst_n || !sys_rst_n)
		(clk_en && stamp_event) |=> s_r.stamp == ($past(cal_time) & rtc_regs_pkg::stamp_time_mask);
	endproperty
	a_stamp_capture: assert property (p_stamp_capture) else $error("stamp time not captured");

	property p_stamp_clear;
		@(posedge clock) disable iff (!rst_n || !sys_rst_n)
		(clk_en && wr_status && !wdata[rtc_regs_pkg::st_stamp_flag] && !stamp_event) |=> !stamp_flag;
	endproperty
	a_stamp_clear: assert property (p_stamp_clear) else $error("stamp flag not cleared");

	property p_key_relock;
		@(posedge clock) disable iff (!rst_n || !sys_rst_n)
		(clk_en && wr_key && s_r.lock == lock_open) |=> s_r.lock == lock_closed;
	endproperty
	a_key_relock: assert property (p_key_relock) else $error("key write did not relock");
endmodule : rtc_alarm_shift_timestamp_regs
`default_nettype wire

// ===== rtc_regs_pkg.sv
// Purpose: Shared constants for the calendar clock alarm, shift and stamp registers.
// Assumes: 32-bit register port, word offsets as byte addresses.
// Notes: Key sequence values and extra offsets are local choices.
package rtc_regs_pkg;
	localparam logic [7:0] off_alarm = 8'h1c;
	localparam logic [7:0] off_key = 8'h24;
	localparam logic [7:0] off_subsec = 8'h28;
	localparam logic [7:0] off_shift = 8'h2c;
	localparam logic [7:0] off_stamp = 8'h30;
	localparam logic [7:0] off_status = 8'h0c;
	localparam logic [7:0] off_control = 8'h08;
	localparam logic [7:0] key_first = 8'hca;
	localparam logic [7:0] key_second = 8'h53;
	localparam int bit_date_ignore = 31;
	localparam int bit_weekday_select = 30;
	localparam int bit_hours_ignore = 23;
	localparam int bit_afternoon = 22;
	localparam int bit_minutes_ignore = 15;
	localparam int bit_seconds_ignore = 7;
	localparam int bit_add_one_second = 31;
	localparam int lsb_date = 24;
	localparam int lsb_hour = 16;
	localparam int lsb_minute = 8;
	localparam int lsb_second = 0;
	localparam logic [31:0] alarm_reset = 32'h0000_0000;
	localparam logic [31:0] stamp_time_mask = 32'h007f_7f7f;
	localparam logic [7:0] date_tens_units_mask = 8'h3f;
	localparam logic [7:0] weekday_units_mask = 8'h0f;
	localparam logic [7:0] hour_field_mask = 8'h7f;
	localparam logic [7:0] ms_field_mask = 8'h7f;
	// Status bit positions.
	localparam int st_alarm_write_allowed = 0;
	localparam int st_shift_pending = 3;
	localparam int st_shadow_synced = 5;
	localparam int st_init = 6;
	localparam int st_alarm_flag = 8;
	localparam int st_stamp_flag = 11;
	localparam int st_unlocked = 16;
	// Control bit positions.
	localparam int ct_shadow_bypass = 5;
	localparam int ct_alarm_enable = 8;
endpackage : rtc_regs_pkg

// ===== testbench.sv
// Purpose: Self-checking bench for the alarm, key, sub-second, shift and stamp registers.
// Assumes: Register port with one-cycle strobes and read data in the following cycle.
// Notes: The clock enable is held high for the whole run.
`timescale 1ns/1ps
`default_nettype none
module testbench;
	logic clock = 1'b0;
	logic rst_n = 1'b0;
	logic sys_rst_n = 1'b0;
	logic [7:0] addr = 8'h00;
	logic [31:0] wdata = 32'h0000_0000;
	logic wr_en = 1'b0;
	logic rd_en = 1'b0;
	logic [31:0] rdata;
	logic [15:0] prescaler_count = 16'h0000;
	logic [31:0] cal_time = 32'h0000_0000;
	logic [31:0] cal_date = 32'h0000_0000;
	logic cal_advance = 1'b0;
	logic shadow_copy = 1'b0;
	logic shift_done = 1'b0;
	logic stamp_event = 1'b0;
	logic shift_add_second;
	logic [14:0] shift_fraction;
	logic shift_strobe;
	logic alarm_flag;
	logic stamp_flag;
	logic shift_pending;
	logic shadow_synced_flag;
	int mismatches = 0;
	int samples_checked = 0;
	logic [31:0] al_tab [7] = '{32'h8012_3457, 32'h8012_3456, 32'h8012_3480, 32'h80a5_3456,
		32'h8012_b556, 32'h0112_3456, 32'h0012_3456};
	logic fl_tab [7] = '{1'b0, 1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 1'b1};
	always #5 clock = ~clock;
	rtc_alarm_shift_timestamp_regs DUT (.clock(clock), .rst_n(rst_n), .sys_rst_n(sys_rst_n),
		.clk_en(1'b1), .addr(addr), .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata),
		.prescaler_count(prescaler_count), .cal_time(cal_time), .cal_date(cal_date),
		.cal_advance(cal_advance), .shadow_copy(shadow_copy), .shift_done(shift_done),
		.stamp_event(stamp_event), .shift_add_second(shift_add_second),
		.shift_fraction(shift_fraction), .shift_strobe(shift_strobe), .alarm_flag(alarm_flag),
		.stamp_flag(stamp_flag), .shift_pending(shift_pending),
		.shadow_synced_flag(shadow_synced_flag));
	// Compares one result and counts it.
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			mismatches++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : check
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clock);
		addr <= a;
		wdata <= d;
		wr_en <= 1'b1;
		@(posedge clock);
		wr_en <= 1'b0;
		#1;
	endtask : wr
	task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
		@(posedge clock);
		addr <= a;
		rd_en <= 1'b1;
		@(posedge clock);
		rd_en <= 1'b0;
		#1;
		check(rdata, exp);
	endtask : rdchk
	// Pulses one event input: 0 advance, 1 shadow copy, 2 shift done, 3 stamp.
	task automatic pulse(input logic [1:0] k);
		@(posedge clock);
		{stamp_event, shift_done, shadow_copy, cal_advance} <= 4'h1 << k;
		@(posedge clock);
		{stamp_event, shift_done, shadow_copy, cal_advance} <= 4'h0;
		#1;
	endtask : pulse
	task automatic unlock;
		wr(rtc_regs_pkg::off_key, 32'(rtc_regs_pkg::key_first));
		wr(rtc_regs_pkg::off_key, 32'(rtc_regs_pkg::key_second));
	endtask : unlock
	// Pulses system reset and reads the sub-second readout in the first cycle after it.
	task automatic sys_reset_read(input logic [31:0] exp);
		@(posedge clock);
		sys_rst_n <= 1'b0;
		@(posedge clock);
		sys_rst_n <= 1'b1;
		addr <= rtc_regs_pkg::off_subsec;
		rd_en <= 1'b1;
		@(posedge clock);
		rd_en <= 1'b0;
		#1;
		check(rdata, exp);
	endtask : sys_reset_read
	task automatic t_regs;
		rdchk(rtc_regs_pkg::off_alarm, 32'h0);
		rdchk(rtc_regs_pkg::off_shift, 32'h0);
		rdchk(rtc_regs_pkg::off_stamp, 32'h0);
		wr(rtc_regs_pkg::off_alarm, 32'h1234_5678);
		rdchk(rtc_regs_pkg::off_alarm, 32'h0);
		unlock();
		rdchk(rtc_regs_pkg::off_key, 32'h0);
		wr(rtc_regs_pkg::off_alarm, 32'hffff_ffff);
		rdchk(rtc_regs_pkg::off_alarm, 32'hffff_ffff);
		wr(rtc_regs_pkg::off_control, 32'h0000_0100);
		wr(rtc_regs_pkg::off_alarm, 32'h0);
		rdchk(rtc_regs_pkg::off_alarm, 32'hffff_ffff);
		wr(rtc_regs_pkg::off_control, 32'h0000_0140);
		wr(rtc_regs_pkg::off_alarm, 32'h0);
		rdchk(rtc_regs_pkg::off_alarm, 32'h0);
		wr(rtc_regs_pkg::off_control, 32'h0);
	endtask : t_regs
	// Masks, week-day mode and exact match, one table row at a time.
	task automatic t_match;
		cal_time <= 32'h0012_3456;
		for (int i = 0; i < 7; i++) begin
			cal_date <= (i == 6) ? 32'h0000_2000 : 32'h0000_0000;
			wr(rtc_regs_pkg::off_alarm, (i == 6) ? 32'h4112_3456 : al_tab[i]);
			wr(rtc_regs_pkg::off_control, 32'h0000_0100);
			pulse(2'd0);
			check({31'h0, alarm_flag}, {31'h0, fl_tab[i]});
			wr(rtc_regs_pkg::off_status, 32'h0);
			wr(rtc_regs_pkg::off_control, 32'h0);
		end
	endtask : t_match
	task automatic t_shift;
		pulse(2'd1);
		check({31'h0, shadow_synced_flag}, 32'h1);
		wr(rtc_regs_pkg::off_shift, 32'h8000_0005);
		check({30'h0, shift_strobe, shift_pending}, 32'h3);
		check({16'h0, shift_add_second, shift_fraction}, 32'h0000_8005);
		check({31'h0, shadow_synced_flag}, 32'h0);
		wr(rtc_regs_pkg::off_shift, 32'h0000_0009);
		check({16'h0, shift_add_second, shift_fraction}, 32'h0000_8005);
		rdchk(rtc_regs_pkg::off_shift, 32'h0);
		pulse(2'd2);
		check({31'h0, shift_pending}, 32'h0);
		wr(rtc_regs_pkg::off_shift, 32'h0000_0003);
		check({16'h0, shift_add_second, shift_fraction}, 32'h0000_0003);
	endtask : t_shift
	task automatic t_stamp;
		cal_time <= 32'hffd2_b4d9;
		pulse(2'd3);
		check({31'h0, stamp_flag}, 32'h1);
		rdchk(rtc_regs_pkg::off_stamp, 32'h0052_3459);
		wr(rtc_regs_pkg::off_status, 32'h0);
		rdchk(rtc_regs_pkg::off_stamp, 32'h0);
	endtask : t_stamp
	task automatic t_sub_and_lock;
		prescaler_count <= 16'hffff;
		repeat (4) @(posedge clock);
		rdchk(rtc_regs_pkg::off_subsec, 32'h0000_ffff);
		sys_reset_read(32'h0);
		rdchk(rtc_regs_pkg::off_alarm, 32'h4112_3456);
		wr(rtc_regs_pkg::off_alarm, 32'h0000_0011);
		rdchk(rtc_regs_pkg::off_alarm, 32'h4112_3456);
		wr(rtc_regs_pkg::off_control, 32'h0000_0020);
		sys_reset_read(32'h0000_ffff);
		wr(rtc_regs_pkg::off_control, 32'h0);
		@(posedge clock);
		rst_n <= 1'b0;
		@(posedge clock);
		rst_n <= 1'b1;
		rdchk(rtc_regs_pkg::off_alarm, 32'h0);
		check({31'h0, shift_pending}, 32'h0);
	endtask : t_sub_and_lock
	task automatic finish_test;
		$display("checks %0d mismatches %0d", samples_checked, mismatches);
		if (mismatches == 0 && samples_checked > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask : finish_test
	initial begin
		repeat (10) @(posedge clock);
		rst_n <= 1'b1;
		sys_rst_n <= 1'b1;
		t_regs();
		t_match();
		t_shift();
		t_stamp();
		t_sub_and_lock();
		finish_test();
	end
	// Cuts a hang short well after the expected 160 or so cycles.
	initial begin
		#100000;
		mismatches++;
		finish_test();
	end
endmodule : testbench
`default_nettype wire
